// file: inc/srfp_pkg.sv
// constants and types shared by the serial register and buffer port
package srfp_pkg;
  // buffer geometry
  localparam logic [6:0] FIFO_DEPTH = 7'h42;
  localparam logic [6:0] PTR_LAST = 7'h41;
  localparam logic [6:0] CNT_EMPTY = 7'h00;
  localparam logic [6:0] PTR_RESET = 7'h00;
  // register address that maps onto the buffer
  localparam logic [6:0] FIFO_ADDR = 7'h00;
  localparam logic [6:0] ADDR_STEP = 7'h01;
  localparam logic [7:0] REG_RESET = 8'h00;
  localparam logic [7:0] REPLY_RESET = 8'h00;
  // serializer
  localparam logic [2:0] BIT_FIRST = 3'h0;
  localparam logic [2:0] BIT_LAST = 3'h7;
  localparam logic [2:0] BIT_STEP = 3'h1;
  localparam logic [15:0] TICK_ONE = 16'h0001;
  localparam logic [15:0] TICK_RESET = 16'h0000;
  // mode settling times
  localparam int CLK_MHZ = 100;
  localparam int SETTLE_NS = 20;
  localparam int TX_EXIT_NS = 2000;
  localparam int SETTLE_CYC_I = (SETTLE_NS * CLK_MHZ + 999) / 1000;
  localparam int TX_EXIT_CYC_I = (TX_EXIT_NS * CLK_MHZ + 999) / 1000;
  localparam logic [7:0] SETTLE_CYC = 8'(SETTLE_CYC_I);
  localparam logic [7:0] TX_EXIT_CYC = 8'(TX_EXIT_CYC_I);
  localparam logic [7:0] SETTLE_STEP = 8'h01;
  localparam logic [7:0] SETTLE_DONE = 8'h00;

  typedef enum logic [3:0] {
    MODE_SLEEP = 4'h1,
    MODE_STANDBY = 4'h2,
    MODE_TX = 4'h4,
    MODE_RX = 4'h8
  } srfp_mode_type;

  typedef enum logic [2:0] {
    SER_IDLE = 3'h1,
    SER_TX = 3'h2,
    SER_RX = 3'h4
  } srfp_ser_type;
endpackage

// file: hw/srfp_top.sv
// serial register port with payload buffer and bit serializer
`timescale 1ns/100ps
// Overview of operation
// - slave only serial port, mode zero
// - host shifts on fall, we sample rise
// - data out changes on falling clock
// - data out released while select high
// - first byte: write flag, 7-bit address
// - data bytes travel most significant first
// - burst increments address after each byte
// - buffer address stays fixed, bytes hit buffer, writes ignored in receive
// - select high ends frame, next needs address
// - write returns register's previous contents
// - one byte-wide buffer of 66 entries
// - transmit serializer sends bytes msb first
// - receive serializer packs bits into bytes
// - not-empty flag frozen during buffer read frame
// - full flag means every entry used
// - write when full sets overrun, drops byte
// - overrun clear also empties buffer
// - packet sent set as last bit goes out
// - level flag against programmable limit
// - level flag changes only on buffer access
// - mode changes keep or empty buffer
module srfp_top (
  input logic clock,
  input logic nrst,
  input logic sck,
  input logic nss,
  input logic mosi,
  output logic miso_out,
  output logic miso_oe,
  input srfp_pkg::srfp_mode_type op_mode,
  input logic [15:0] bit_period,
  input logic [6:0] buffer_level_limit,
  input logic buffer_overflow_clear,
  input logic demod_data,
  output logic modulator_data,
  output logic buffer_has_data_flag,
  output logic buffer_all_occupied_flag,
  output logic buffer_overflow_flag,
  output logic buffer_threshold_flag,
  output logic frame_transmitted_flag,
  output logic mode_settled_flag
);

  typedef struct packed {
    logic [2:0] nss_s;
    logic [2:0] tgl_s;
    logic [1:0] dem_s;
    logic first;
    logic wnr;
    logic [6:0] addr;
    logic hold;
    logic [7:0] reply;
    logic [65:0][7:0] fifo;
    logic [6:0] rd;
    logic [6:0] wr;
    logic [6:0] cnt;
    logic [127:0][7:0] regs;
    srfp_pkg::srfp_mode_type mode;
    srfp_pkg::srfp_ser_type ser;
    logic [7:0] sr;
    logic [2:0] bits;
    logic [15:0] tick;
    logic mod_data;
    logic has;
    logic full;
    logic ovf;
    logic lvl;
    logic sent;
    logic settled;
    logic [7:0] settle;
  } srfp_core_type;

  srfp_core_type st;
  srfp_core_type next_st;

  // link side, clocked by the host's serial clock
  logic [2:0] spi_bit;
  logic [7:0] spi_in;
  logic [7:0] spi_byte;
  logic spi_tgl;
  logic [7:0] spi_out;
  logic spi_miso;
  logic spi_oe;

  logic frame_start;
  logic frame_end;
  logic byte_evt;
  logic changed;
  logic mode_clear;
  logic host_push;
  logic host_pop;
  logic ser_push;
  logic ser_pop;
  logic push_req;
  logic pop_req;
  logic do_push;
  logic do_pop;
  logic clr;
  logic tick_hit;
  logic last_bit;
  logic fifo_reply;
  logic [7:0] push_byte;
  logic [15:0] tick_reload;

  function automatic logic [6:0] ptr_next(input logic [6:0] p);
    ptr_next = (p == srfp_pkg::PTR_LAST) ? srfp_pkg::PTR_RESET : p + srfp_pkg::ADDR_STEP;
  endfunction

  // select high clears the bit position, so every frame starts on a byte edge
  always_ff @(posedge sck or posedge nss) begin
    if (nss) begin
      spi_bit <= srfp_pkg::BIT_FIRST;
      spi_in <= srfp_pkg::REG_RESET;
    end else begin
      spi_bit <= spi_bit + srfp_pkg::BIT_STEP;
      spi_in <= {spi_in[6:0], mosi};
    end
  end

  // byte and toggle survive the frame end so the core can still take them
  always_ff @(posedge sck or negedge nrst) begin
    if (!nrst) begin
      spi_byte <= srfp_pkg::REG_RESET;
      spi_tgl <= 1'b0;
    end else if (spi_bit == srfp_pkg::BIT_LAST) begin
      spi_byte <= {spi_in[6:0], mosi};
      spi_tgl <= ~spi_tgl;
    end
  end

  // reply word is read here without a handshake: the host must leave a
  // gap between bytes so that the core has settled it before the next fall
  always_ff @(negedge sck or posedge nss) begin
    if (nss) begin
      spi_oe <= 1'b0;
      spi_miso <= 1'b0;
      spi_out <= srfp_pkg::REG_RESET;
    end else begin
      spi_oe <= 1'b1;
      if (spi_bit == srfp_pkg::BIT_FIRST) begin
        spi_miso <= st.reply[7];
        spi_out <= {st.reply[6:0], 1'b0};
      end else begin
        spi_miso <= spi_out[7];
        spi_out <= {spi_out[6:0], 1'b0};
      end
    end
  end

  always_comb begin
    next_st = st;
    next_st.nss_s = {st.nss_s[1:0], nss};
    next_st.tgl_s = {st.tgl_s[1:0], spi_tgl};
    next_st.dem_s = {st.dem_s[0], demod_data};
    frame_start = st.nss_s[2] & ~st.nss_s[1];
    frame_end = st.nss_s[1];
    byte_evt = st.tgl_s[2] ^ st.tgl_s[1];
    host_push = 1'b0;
    host_pop = 1'b0;
    ser_push = 1'b0;
    ser_pop = 1'b0;
    last_bit = 1'b0;
    fifo_reply = 1'b0;
    push_byte = spi_byte;
    tick_hit = (st.tick == srfp_pkg::TICK_RESET);
    tick_reload = (bit_period == srfp_pkg::TICK_RESET) ? srfp_pkg::TICK_RESET
                : bit_period - srfp_pkg::TICK_ONE;

    // mode tracking and buffer clearing on mode change
    next_st.mode = op_mode;
    changed = (op_mode != st.mode);
    mode_clear = changed & ((op_mode == srfp_pkg::MODE_RX)
               | (st.mode == srfp_pkg::MODE_TX)
               | ((st.mode == srfp_pkg::MODE_RX) & (op_mode == srfp_pkg::MODE_TX)));

    // host bytes arriving from the link
    if (byte_evt) begin
      if (st.first) begin
        next_st.first = 1'b0;
        next_st.wnr = spi_byte[7];
        next_st.addr = spi_byte[6:0];
        next_st.hold = (spi_byte[6:0] == srfp_pkg::FIFO_ADDR) & ~spi_byte[7];
        if (spi_byte[6:0] == srfp_pkg::FIFO_ADDR) begin
          fifo_reply = 1'b1;
        end else begin
          next_st.reply = st.regs[spi_byte[6:0]];
        end
      end else if (st.addr == srfp_pkg::FIFO_ADDR) begin
        fifo_reply = 1'b1;
        if (st.wnr) begin
          host_push = (st.mode != srfp_pkg::MODE_RX);
        end else begin
          host_pop = 1'b1;
        end
      end else begin
        if (st.wnr) begin
          next_st.regs[st.addr] = spi_byte;
        end
        next_st.addr = st.addr + srfp_pkg::ADDR_STEP;
        next_st.reply = st.regs[st.addr + srfp_pkg::ADDR_STEP];
      end
    end
    if (frame_end) begin
      next_st.first = 1'b1;
      next_st.hold = 1'b0;
    end

    // bit serializer
    next_st.tick = tick_hit ? tick_reload : st.tick - srfp_pkg::TICK_ONE;
    case (st.ser)
      srfp_pkg::SER_IDLE: begin
        if ((st.mode == srfp_pkg::MODE_TX) && (st.cnt != srfp_pkg::CNT_EMPTY)
            && !host_push && !host_pop) begin
          ser_pop = 1'b1;
          next_st.sr = st.fifo[st.rd];
          next_st.bits = srfp_pkg::BIT_FIRST;
          next_st.tick = tick_reload;
          next_st.ser = srfp_pkg::SER_TX;
        end else if (st.mode == srfp_pkg::MODE_RX) begin
          next_st.bits = srfp_pkg::BIT_FIRST;
          next_st.tick = tick_reload;
          next_st.ser = srfp_pkg::SER_RX;
        end
      end
      srfp_pkg::SER_TX: begin
        if (tick_hit) begin
          next_st.mod_data = st.sr[7];
          next_st.sr = {st.sr[6:0], 1'b0};
          next_st.bits = st.bits + srfp_pkg::BIT_STEP;
          if (st.bits == srfp_pkg::BIT_LAST) begin
            next_st.ser = srfp_pkg::SER_IDLE;
            last_bit = (st.cnt == srfp_pkg::CNT_EMPTY) & ~host_push;
          end
        end
      end
      srfp_pkg::SER_RX: begin
        if (tick_hit) begin
          next_st.sr = {st.sr[6:0], st.dem_s[1]};
          next_st.bits = st.bits + srfp_pkg::BIT_STEP;
          if (st.bits == srfp_pkg::BIT_LAST) begin
            ser_push = 1'b1;
            push_byte = {st.sr[6:0], st.dem_s[1]};
          end
        end
      end
      default: begin
        next_st.ser = srfp_pkg::SER_IDLE;
      end
    endcase
    if (changed) begin
      next_st.ser = srfp_pkg::SER_IDLE;
    end

    // buffer; host and serializer never push in the same cycle
    clr = mode_clear | buffer_overflow_clear;
    push_req = host_push | ser_push;
    pop_req = host_pop | ser_pop;
    do_push = push_req & (st.cnt != srfp_pkg::FIFO_DEPTH);
    do_pop = pop_req & (st.cnt != srfp_pkg::CNT_EMPTY);
    if (do_push) begin
      next_st.fifo[st.wr] = push_byte;
      next_st.wr = ptr_next(st.wr);
    end
    if (do_pop) begin
      next_st.rd = ptr_next(st.rd);
    end
    next_st.cnt = st.cnt + {6'h00, do_push} - {6'h00, do_pop};
    if (clr) begin
      next_st.rd = srfp_pkg::PTR_RESET;
      next_st.wr = srfp_pkg::PTR_RESET;
      next_st.cnt = srfp_pkg::CNT_EMPTY;
    end
    if (fifo_reply) begin
      next_st.reply = next_st.fifo[next_st.rd];
    end

    // flags
    next_st.full = (next_st.cnt == srfp_pkg::FIFO_DEPTH);
    if (!next_st.hold || frame_start) begin
      next_st.has = (next_st.cnt != srfp_pkg::CNT_EMPTY);
    end
    // a new overrun wins over a clear in the same cycle
    next_st.ovf = (push_req & (st.cnt == srfp_pkg::FIFO_DEPTH))
                | (st.ovf & ~buffer_overflow_clear);
    if (do_push || do_pop || clr) begin
      next_st.lvl = (next_st.cnt > buffer_level_limit);
    end
    next_st.sent = last_bit | (st.sent & ~(changed & (st.mode == srfp_pkg::MODE_TX)));

    // leaving transmit takes longer, the modem must ramp down first
    if (changed) begin
      next_st.settled = 1'b0;
      next_st.settle = (st.mode == srfp_pkg::MODE_TX) ? srfp_pkg::TX_EXIT_CYC
                     : srfp_pkg::SETTLE_CYC;
    end else if (st.settle != srfp_pkg::SETTLE_DONE) begin
      next_st.settle = st.settle - srfp_pkg::SETTLE_STEP;
    end else begin
      next_st.settled = 1'b1;
    end
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      st <= '0;
      st.nss_s <= 3'h7;
      st.first <= 1'b1;
      st.mode <= srfp_pkg::MODE_SLEEP;
      st.ser <= srfp_pkg::SER_IDLE;
      st.settled <= 1'b1;
    end else begin
      st <= next_st;
    end
  end

  assign miso_out = spi_miso;
  assign miso_oe = spi_oe;
  assign modulator_data = st.mod_data;
  assign buffer_has_data_flag = st.has;
  assign buffer_all_occupied_flag = st.full;
  assign buffer_overflow_flag = st.ovf;
  assign buffer_threshold_flag = st.lvl;
  assign frame_transmitted_flag = st.sent;
  assign mode_settled_flag = st.settled;

  a_full_exact: assert property (@(posedge clock) disable iff (!nrst)
    buffer_all_occupied_flag == (st.cnt == srfp_pkg::FIFO_DEPTH))
    else $error("full flag disagrees with count");

  a_ovf_set: assert property (@(posedge clock) disable iff (!nrst)
    (push_req && st.cnt == srfp_pkg::FIFO_DEPTH && !pop_req && !clr)
    |=> (buffer_overflow_flag && st.cnt == srfp_pkg::FIFO_DEPTH && $stable(st.wr)))
    else $error("overrun not flagged or byte stored");

  a_ovf_clear: assert property (@(posedge clock) disable iff (!nrst)
    (buffer_overflow_clear && !push_req)
    |=> (!buffer_overflow_flag && st.cnt == srfp_pkg::CNT_EMPTY))
    else $error("overrun clear did not empty buffer");

  a_lvl_hold: assert property (@(posedge clock) disable iff (!nrst)
    !(do_push || do_pop || clr) |=> $stable(buffer_threshold_flag))
    else $error("level flag moved without access");

  a_lvl_value: assert property (@(posedge clock) disable iff (!nrst)
    (do_push || do_pop || clr)
    |=> buffer_threshold_flag == (st.cnt > $past(buffer_level_limit)))
    else $error("level flag wrong after access");

  a_empty_read: assert property (@(posedge clock) disable iff (!nrst)
    (host_pop && st.cnt == srfp_pkg::CNT_EMPTY && !push_req && !clr)
    |=> (st.cnt == srfp_pkg::CNT_EMPTY && $stable(st.rd)))
    else $error("empty read altered buffer");

  a_mode_clear: assert property (@(posedge clock) disable iff (!nrst)
    mode_clear |=> st.cnt == srfp_pkg::CNT_EMPTY ##1 st.cnt <= 7'h01)
    else $error("buffer not emptied on mode change");

  a_burst_step: assert property (@(posedge clock) disable iff (!nrst)
    (byte_evt && !st.first && st.addr != srfp_pkg::FIFO_ADDR)
    |=> st.addr == $past(st.addr) + srfp_pkg::ADDR_STEP)
    else $error("burst address did not advance");

  a_fifo_fixed: assert property (@(posedge clock) disable iff (!nrst)
    (byte_evt && !st.first && st.addr == srfp_pkg::FIFO_ADDR && !frame_end)
    |-> (push_req || pop_req || st.mode == srfp_pkg::MODE_RX)
    ##1 st.addr == srfp_pkg::FIFO_ADDR)
    else $error("buffer access lost or address moved");

  a_sent_set: assert property (@(posedge clock) disable iff (!nrst)
    last_bit |=> frame_transmitted_flag && modulator_data == $past(st.sr[7]))
    else $error("packet sent flag missing");

  a_tx_msb: assert property (@(posedge clock) disable iff (!nrst)
    (st.ser == srfp_pkg::SER_TX && tick_hit) |=> modulator_data == $past(st.sr[7]))
    else $error("serializer bit order wrong");

  a_has_data: assert property (@(posedge clock) disable iff (!nrst)
    (!st.hold && !$past(st.hold)) |-> buffer_has_data_flag == (st.cnt != 7'h00))
    else $error("not-empty flag disagrees with count");
endmodule

// file: verification/srfp_host_model.sv
// host bus master model for the serial register port
`timescale 1ns/100ps
module srfp_host_model (
  output logic sck,
  output logic nss,
  output logic mosi,
  input wire logic miso_out,
  input wire logic miso_oe
);
  logic last;

  initial begin
    sck = 1'b0;
    nss = 1'b1;
    mosi = 1'b0;
    last = 1'b0;
  end

  // released wire reads as the inverse of its last level, never a guess
  task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
    for (int i = 7; i >= 0; i--) begin
      mosi = tx[i];
      #7.5 sck = 1'b1;
      rx[i] = miso_oe ? miso_out : ~last;
      last = rx[i];
      // sck held high after the eighth rise: the next fall loads the reply,
      // which needs the gap to cross from the core side first
      if (i == 0) begin
        #100;
      end else begin
        #7.5;
      end
      sck = 1'b0;
    end
  endtask

  task automatic start(input logic wnr, input logic [6:0] addr);
    logic [7:0] dummy;
    nss = 1'b0;
    #20;
    xfer({wnr, addr}, dummy);
  endtask

  task automatic close_frame();
    nss = 1'b1;
    mosi = ~mosi;
    #60;
  endtask
endmodule

// file: verification/tb_srfp_top.sv
// self-checking bench for the serial register and buffer port
`timescale 1ns/100ps
module tb_srfp_top;
  logic clock = 1'b0;
  logic nrst;
  logic sck, nss, mosi, miso_out, miso_oe;
  srfp_pkg::srfp_mode_type op_mode;
  logic [15:0] bit_period;
  logic [6:0] buffer_level_limit;
  logic buffer_overflow_clear;
  logic [4:0] cnt = 5'h00;
  logic modulator_data, buffer_has_data_flag, buffer_all_occupied_flag;
  logic buffer_overflow_flag, buffer_threshold_flag, frame_transmitted_flag;
  logic mode_settled_flag;
  int fails = 0;
  int checked = 0;

  initial begin
    forever #5 clock = ~clock;
  end
  // demod stream 11110000 repeated, one bit per four cycles
  always @(negedge clock) cnt <= cnt + 5'h01;

  srfp_top srfp_top_inst (.clock(clock), .nrst(nrst), .sck(sck), .nss(nss),
    .mosi(mosi), .miso_out(miso_out), .miso_oe(miso_oe), .op_mode(op_mode),
    .bit_period(bit_period), .buffer_level_limit(buffer_level_limit),
    .buffer_overflow_clear(buffer_overflow_clear), .demod_data(cnt[4]),
    .modulator_data(modulator_data), .buffer_has_data_flag(buffer_has_data_flag),
    .buffer_all_occupied_flag(buffer_all_occupied_flag),
    .buffer_overflow_flag(buffer_overflow_flag),
    .buffer_threshold_flag(buffer_threshold_flag),
    .frame_transmitted_flag(frame_transmitted_flag),
    .mode_settled_flag(mode_settled_flag));

  srfp_host_model srfp_host_model_inst (.sck(sck), .nss(nss), .mosi(mosi),
    .miso_out(miso_out), .miso_oe(miso_oe));

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checked++;
    if (got !== exp) begin
      fails++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // polls a status output picked by sel for up to n cycles
  task automatic wait_flag(input int sel, input logic v, input int n);
    logic f;
    for (int i = 0; i < n; i++) begin
      case (sel)
        0: f = mode_settled_flag;
        1: f = modulator_data;
        default: f = frame_transmitted_flag;
      endcase
      if (f === v) break;
      @(negedge clock);
    end
  endtask

  task automatic wr(input logic [6:0] a, input logic [7:0] d, input logic [7:0] old);
    logic [7:0] r;
    srfp_host_model_inst.start(1'b1, a);
    srfp_host_model_inst.xfer(d, r);
    srfp_host_model_inst.close_frame();
    if (a != srfp_pkg::FIFO_ADDR) chk(r, old);
  endtask

  task automatic rd(input logic [6:0] a, output logic [7:0] r);
    srfp_host_model_inst.start(1'b0, a);
    srfp_host_model_inst.xfer(8'h00, r);
    srfp_host_model_inst.close_frame();
  endtask

  task automatic mode(input srfp_pkg::srfp_mode_type m);
    @(negedge clock) op_mode = m;
    @(negedge clock);
    chk(mode_settled_flag, 1'b0);
    repeat (3) @(negedge clock);
    wait_flag(0, 1'b1, 300);
    chk(mode_settled_flag, 1'b1);
  endtask

  task automatic t_regs();
    logic [7:0] r;
    wr(7'h05, 8'hA5, 8'h00);
    rd(7'h05, r);
    chk(r, 8'hA5);
    srfp_host_model_inst.start(1'b1, 7'h10);
    for (int i = 1; i < 4; i++) srfp_host_model_inst.xfer(8'h11 * i[7:0], r);
    srfp_host_model_inst.close_frame();
    srfp_host_model_inst.start(1'b0, 7'h10);
    for (int i = 1; i < 4; i++) begin
      srfp_host_model_inst.xfer(8'h00, r);
      chk(r, 8'h11 * i[7:0]);
    end
    srfp_host_model_inst.close_frame();
  endtask

  task automatic t_buffer();
    logic [7:0] r;
    mode(srfp_pkg::MODE_STANDBY);
    @(negedge clock) buffer_level_limit = 7'h0A;
    srfp_host_model_inst.start(1'b1, srfp_pkg::FIFO_ADDR);
    for (int i = 0; i < 65; i++) srfp_host_model_inst.xfer(i[7:0], r);
    srfp_host_model_inst.close_frame();
    chk(buffer_all_occupied_flag, 1'b0);
    wr(srfp_pkg::FIFO_ADDR, 8'h41, 8'h00);
    chk(buffer_all_occupied_flag, 1'b1);
    chk(buffer_threshold_flag, 1'b1);
    chk(buffer_overflow_flag, 1'b0);
    wr(srfp_pkg::FIFO_ADDR, 8'hEE, 8'h00);
    chk(buffer_overflow_flag, 1'b1);
    @(negedge clock) buffer_level_limit = 7'h7F;
    repeat (10) @(negedge clock);
    chk(buffer_threshold_flag, 1'b1);
    srfp_host_model_inst.start(1'b0, srfp_pkg::FIFO_ADDR);
    for (int i = 0; i < 2; i++) begin
      srfp_host_model_inst.xfer(8'h00, r);
      chk(r, i[7:0]);
    end
    srfp_host_model_inst.close_frame();
    chk(buffer_threshold_flag, 1'b0);
    @(negedge clock) buffer_overflow_clear = 1'b1;
    @(negedge clock) buffer_overflow_clear = 1'b0;
    repeat (3) @(negedge clock);
    chk(buffer_overflow_flag, 1'b0);
    chk(buffer_has_data_flag, 1'b0);
    wr(srfp_pkg::FIFO_ADDR, 8'h5A, 8'h00);
    srfp_host_model_inst.start(1'b0, srfp_pkg::FIFO_ADDR);
    srfp_host_model_inst.xfer(8'h00, r);
    chk(r, 8'h5A);
    chk(buffer_has_data_flag, 1'b1);
    srfp_host_model_inst.close_frame();
    chk(buffer_has_data_flag, 1'b0);
    rd(srfp_pkg::FIFO_ADDR, r);
    chk(buffer_has_data_flag, 1'b0);
    chk(buffer_overflow_flag, 1'b0);
  endtask

  task automatic t_tx();
    logic [7:0] b;
    wr(srfp_pkg::FIFO_ADDR, 8'hA5, 8'h00);
    @(negedge clock) op_mode = srfp_pkg::MODE_TX;
    wait_flag(1, 1'b1, 60);
    for (int i = 7; i >= 0; i--) begin
      b[i] = modulator_data;
      repeat (4) @(negedge clock);
    end
    chk(b, 8'hA5);
    wait_flag(2, 1'b1, 20);
    chk(frame_transmitted_flag, 1'b1);
    mode(srfp_pkg::MODE_STANDBY);
  endtask

  task automatic t_rx();
    logic [7:0] r, q;
    logic [15:0] w;
    logic ok;
    wr(srfp_pkg::FIFO_ADDR, 8'h77, 8'h00);
    mode(srfp_pkg::MODE_SLEEP);
    chk(buffer_has_data_flag, 1'b1);
    mode(srfp_pkg::MODE_RX);
    chk(buffer_has_data_flag, 1'b0);
    repeat (100) @(negedge clock);
    mode(srfp_pkg::MODE_STANDBY);
    rd(srfp_pkg::FIFO_ADDR, r);
    rd(srfp_pkg::FIFO_ADDR, q);
    ok = 1'b0;
    for (int k = 0; k < 8; k++) begin
      w = 16'hF0F0 >> k;
      if (w[7:0] === r) ok = 1'b1;
    end
    chk(ok, 1'b1);
    chk(q, r);
  endtask

  task automatic results();
    $display("checked=%0d fails=%0d", checked, fails);
    if (fails == 0 && checked > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  initial begin
    #200000;
    fails++;
    results();
  end

  initial begin
    nrst = 1'b0;
    op_mode = srfp_pkg::MODE_SLEEP;
    bit_period = 16'h0004;
    buffer_level_limit = 7'h0A;
    buffer_overflow_clear = 1'b0;
    repeat (16) @(negedge clock);
    nrst = 1'b1;
    repeat (6) @(negedge clock);
    chk(miso_oe, 1'b0);
    chk(buffer_has_data_flag, 1'b0);
    chk(frame_transmitted_flag, 1'b0);
    t_regs();
    t_buffer();
    t_tx();
    t_rx();
    results();
  end
endmodule
